// File: common/cscs_defines.vh
// Purpose: constants for the CPU system clock select block
// Assumes: Wishbone byte addresses, 32-bit data
// Notes: included by both design files
`ifndef CSCS_DEFINES_VH
`define CSCS_DEFINES_VH
`define CSCS_ADR_PCS 4'h0
`define CSCS_ADR_SCS 4'h4
`define CSCS_ADR_CMD 4'h8
`define CSCS_ADR_STAT 4'hC
`define CSCS_PCS_RESET 4'h0
`define CSCS_SCS_RESET 4'h0
`define CSCS_BIT_SRC 0
`define CSCS_BIT_OSTOP 3
`define CSCS_BIT_HALT 2
`define CSCS_BIT_STOP 3
`define CSCS_CMD_STOP 2'h1
`define CSCS_CMD_HALT 2'h2
`define CSCS_DIV64 2'h0
`define CSCS_DIV16 2'h1
`define CSCS_DIV8 2'h2
`define CSCS_DIV4 2'h3
`define CSCS_DLY_FROM64 6'h01
`define CSCS_DLY_FROM16 6'h04
`define CSCS_DLY_FROM8 6'h08
`define CSCS_DLY_FROM4 6'h10
`define CSCS_DLY_FROMSUB 6'h01
`define CSCS_DLY_TOSUB 6'h20
`define CSCS_SUB_DIV 2'h3
`endif

// File: design/cscs_mcycle.v
// Purpose: machine cycle tick generator for the selected CPU clock divisor
// Assumes: sub_tick is a one-cycle pulse already in the sys_clk domain
// Notes: divisor value is held by the caller and may change at any tick
`timescale 1ns/1ps
`default_nettype none
`include "cscs_defines.vh"
module cscs_mcycle (
	input wire sys_clk,
	input wire resetn,
	input wire use_sub,
	input wire [1:0] div_sel,
	input wire sub_tick,
	output reg tick
);
	reg [5:0] cnt;
	reg [5:0] limit;
	reg [1:0] sub_cnt;
	always @* begin
		case (div_sel)
			`CSCS_DIV64: limit = 6'h3F;
			`CSCS_DIV16: limit = 6'h0F;
			`CSCS_DIV8: limit = 6'h07;
			`CSCS_DIV4: limit = 6'h03;
			default: limit = 6'h3F;
		endcase
	end
	always @(posedge sys_clk) begin
		if (!resetn) begin
			cnt <= 6'h00;
			sub_cnt <= 2'h0;
			tick <= 1'b0;
		end else if (use_sub) begin
			// Subsystem: one machine cycle per four sub clocks
			cnt <= 6'h00;
			tick <= sub_tick && (sub_cnt == `CSCS_SUB_DIV);
			if (sub_tick) begin
				sub_cnt <= sub_cnt + 2'h1;
			end
		end else begin
			sub_cnt <= 2'h0;
			tick <= (cnt >= limit);
			cnt <= (cnt >= limit) ? 6'h00 : cnt + 6'h01;
		end
	end
endmodule // cscs_mcycle
`default_nettype wire

// File: design/cscs_top.v
// Purpose: CPU clock select, standby request and main/sub clock switching
// Assumes: classic Wishbone slave, one wait state; subsystem clock on a pin
// Notes: clock changes are applied after a machine cycle delay
// Contract
// RULE_01: processor clock register: divider and mode bits
// RULE_02: mode bits enter standby, release clears them
// RULE_03: register write updates low bits, clears high
// RULE_04: stop sets bit three, halt bit two
// RULE_05: stop and halt ignore bank enable flag
// RULE_06: on subsystem clock use sub over four
// RULE_07: divider applies only on main clock
// RULE_08: stop allowed only on main clock
// RULE_09: reset clears processor clock register
// RULE_10: system clock register: source and oscillator stop
// RULE_11: source and stop bit change separately
// RULE_12: system bits ignore bank enable flag
// RULE_13: software stops oscillator only on subsystem
// RULE_14: oscillator stop on main is no stop mode
// RULE_15: reset clears system clock register
// RULE_16: software waits before stopping main oscillator
// RULE_17: stop bit grounds main oscillator input pin
// RULE_18: external main clock forbids stop mode
// RULE_19: never go subsystem with divide-by-16
// RULE_20: clock switch is delayed machine cycles
// RULE_21: delays 1, 4, 8, 16 cycles
// RULE_22: oscillator stop after 32 cycles
// RULE_23: divisors 64, 16, 8, 4
`timescale 1ns/1ps
`default_nettype none
`include "cscs_defines.vh"
module cscs_top (
	input wire sys_clk,
	input wire resetn,
	input wire [3:0] wb_adr_i,
	input wire [31:0] wb_dat_i,
	input wire wb_we_i,
	input wire [3:0] wb_sel_i,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	input wire memory_bank_enable_flag,
	input wire standby_release,
	input wire sub_clk_pin,
	output reg cpu_clk_tick,
	output reg stop_mode,
	output reg halt_mode,
	output reg main_osc_input_pin_gnd,
	output reg main_osc_enable,
	output reg cpu_on_sub,
	output reg [1:0] cpu_div_active
);
	////////////////////////////////////////////////////////////////////////////
	reg [3:0] processor_clock_select_reg;
	reg [3:0] system_clock_select_reg;
	reg sub_s1;
	reg sub_s2;
	reg sub_s3;
	reg [1:0] act_div;
	reg act_sub;
	reg [5:0] dly_cnt;
	reg pend;
	reg [1:0] pend_div;
	reg pend_sub;
	reg [5:0] next_dly;
	wire sub_tick;
	wire mc_tick;
	wire wr_stb;
	wire rd_stb;
	wire clock_source_bit;
	wire main_osc_stop_bit;
	assign clock_source_bit = system_clock_select_reg[`CSCS_BIT_SRC];
	assign main_osc_stop_bit = system_clock_select_reg[`CSCS_BIT_OSTOP];
	assign wr_stb = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];
	assign rd_stb = wb_cyc_i && wb_stb_i && !wb_ack_o;
	////////////////////////////////////////////////////////////////////////////
	// Subsystem clock pin is foreign: two flops, then edge detect on the second
	always @(posedge sys_clk) begin
		if (!resetn) begin
			sub_s1 <= 1'b0;
			sub_s2 <= 1'b0;
			sub_s3 <= 1'b0;
		end else begin
			sub_s1 <= sub_clk_pin;
			sub_s2 <= sub_s1;
			sub_s3 <= sub_s2;
		end
	end
	assign sub_tick = sub_s2 && !sub_s3;
	cscs_mcycle u_mcycle (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.use_sub(act_sub), // [RULE_06]
		.div_sel(act_div), // [RULE_07] [RULE_23]
		.sub_tick(sub_tick),
		.tick(mc_tick)
	);
	////////////////////////////////////////////////////////////////////////////
	// Wait depends on the setting in force before the change
	always @* begin
		if (act_sub) begin
			next_dly = `CSCS_DLY_FROMSUB; // [RULE_21]
		end else if (clock_source_bit) begin
			// Worst case for the main to sub crossing
			next_dly = `CSCS_DLY_TOSUB; // [RULE_22]
		end else begin
			case (act_div)
				`CSCS_DIV64: next_dly = `CSCS_DLY_FROM64; // [RULE_21]
				`CSCS_DIV16: next_dly = `CSCS_DLY_FROM16;
				`CSCS_DIV8: next_dly = `CSCS_DLY_FROM8;
				`CSCS_DIV4: next_dly = `CSCS_DLY_FROM4;
				default: next_dly = `CSCS_DLY_FROM64;
			endcase
		end
	end
	////////////////////////////////////////////////////////////////////////////
	// Registers and Wishbone slave; bank enable flag is not consulted at all
	always @(posedge sys_clk) begin
		if (!resetn) begin
			processor_clock_select_reg <= `CSCS_PCS_RESET; // [RULE_09]
			system_clock_select_reg <= `CSCS_SCS_RESET; // [RULE_15]
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			wb_ack_o <= rd_stb;
			wb_dat_o <= 32'h00000000;
			if (rd_stb && !wb_we_i) begin
				case (wb_adr_i)
					`CSCS_ADR_PCS: wb_dat_o <= {28'h0000000, processor_clock_select_reg};
					`CSCS_ADR_SCS: wb_dat_o <= {28'h0000000, system_clock_select_reg};
					`CSCS_ADR_STAT: wb_dat_o <= {26'h0000000, pend, act_sub, act_div, halt_mode,
						stop_mode};
					default: wb_dat_o <= 32'h00000000;
				endcase
			end
			// Release has priority: a pending release ends standby
			if (standby_release) begin
				processor_clock_select_reg[3:2] <= 2'h0; // [RULE_02]
			end
			if (wr_stb && wb_adr_i == `CSCS_ADR_PCS) begin
				processor_clock_select_reg <= {2'h0, wb_dat_i[1:0]}; // [RULE_03] [RULE_01]
			end
			if (wr_stb && wb_adr_i == `CSCS_ADR_CMD && !standby_release) begin
				// Stop refused on the subsystem clock; halt accepted unless standby_release is high
				if (wb_dat_i[1:0] == `CSCS_CMD_STOP && !act_sub && !clock_source_bit) begin
					processor_clock_select_reg[`CSCS_BIT_STOP] <= 1'b1; // [RULE_04] [RULE_08] [RULE_05]
				end
				if (wb_dat_i[1:0] == `CSCS_CMD_HALT) begin
					processor_clock_select_reg[`CSCS_BIT_HALT] <= 1'b1; // [RULE_04]
				end
			end
			if (wr_stb && wb_adr_i == `CSCS_ADR_SCS) begin
				// Only one of the two bits may change per write [RULE_11] [RULE_12]
				if (wb_dat_i[0] != clock_source_bit) begin
					system_clock_select_reg[`CSCS_BIT_SRC] <= wb_dat_i[0]; // [RULE_10]
				end else begin
					system_clock_select_reg[`CSCS_BIT_OSTOP] <= wb_dat_i[3]; // [RULE_10]
				end
			end
		end
	end
	////////////////////////////////////////////////////////////////////////////
	// Delayed adoption of new clock setting
	always @(posedge sys_clk) begin
		if (!resetn) begin
			act_div <= `CSCS_DIV64;
			act_sub <= 1'b0;
			pend <= 1'b0;
			pend_div <= `CSCS_DIV64;
			pend_sub <= 1'b0;
			dly_cnt <= 6'h00;
		end else if (!pend) begin
			if (processor_clock_select_reg[1:0] != act_div || clock_source_bit != act_sub) begin
				pend <= 1'b1; // [RULE_20]
				pend_div <= processor_clock_select_reg[1:0];
				pend_sub <= clock_source_bit;
				dly_cnt <= next_dly;
			end
		end else if (mc_tick) begin
			if (dly_cnt <= 6'h01) begin
				act_div <= pend_div; // [RULE_21]
				act_sub <= pend_sub;
				pend <= 1'b0;
			end else begin
				dly_cnt <= dly_cnt - 6'h01;
			end
		end
	end
	////////////////////////////////////////////////////////////////////////////
	// Outputs, all registered
	always @(posedge sys_clk) begin
		if (!resetn) begin
			cpu_clk_tick <= 1'b0;
			stop_mode <= 1'b0;
			halt_mode <= 1'b0;
			main_osc_input_pin_gnd <= 1'b0;
			main_osc_enable <= 1'b1;
			cpu_on_sub <= 1'b0;
			cpu_div_active <= `CSCS_DIV64;
		end else begin
			cpu_clk_tick <= mc_tick;
			stop_mode <= processor_clock_select_reg[`CSCS_BIT_STOP]; // [RULE_02]
			halt_mode <= processor_clock_select_reg[`CSCS_BIT_HALT];
			// Oscillator stop bit alone never raises stop_mode [RULE_14]
			main_osc_input_pin_gnd <= main_osc_stop_bit
				|| processor_clock_select_reg[`CSCS_BIT_STOP]; // [RULE_17]
			main_osc_enable <= !(main_osc_stop_bit
				|| processor_clock_select_reg[`CSCS_BIT_STOP]);
			cpu_on_sub <= act_sub; // [RULE_06]
			cpu_div_active <= act_div;
		end
	end
endmodule // cscs_top
`default_nettype wire

// File: dv/cscs_checker.sv
// Purpose: port checker for cscs_top
// Assumes: one clock, sync active low reset
// Notes: bound to every cscs_top instance
`timescale 1ns/1ps
`default_nettype none
module cscs_checker (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic [3:0] wb_adr_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire logic standby_release,
	input wire logic cpu_clk_tick,
	input wire logic stop_mode,
	input wire logic halt_mode,
	input wire logic main_osc_input_pin_gnd,
	input wire logic main_osc_enable,
	input wire logic cpu_on_sub
);
default clocking @(posedge sys_clk); endclocking
default disable iff (!resetn);
sequence s_req;
	wb_cyc_i && wb_stb_i && !wb_ack_o;
endsequence
sequence s_pcw;
	s_req ##0 (wb_we_i && wb_sel_i[0] && wb_adr_i == 4'h0);
endsequence
////////////////////////////////////////////////////////////
property p_ack; s_req |=> wb_ack_o; endproperty
a_ack: assert property (p_ack) else $error("no ack");
property p_pulse; wb_ack_o |=> !wb_ack_o; endproperty
a_pulse: assert property (p_pulse) else $error("long ack");
property p_osc; main_osc_enable != main_osc_input_pin_gnd; endproperty
a_osc: assert property (p_osc) else $error("osc enable");
property p_stg; stop_mode [*2] |-> main_osc_input_pin_gnd; endproperty
a_stg: assert property (p_stg) else $error("stop ungrounded");
property p_rel; standby_release |-> ##[1:2] !stop_mode && !halt_mode; endproperty
a_rel: assert property (p_rel) else $error("release");
property p_pcw; s_pcw |-> ##[1:3] !stop_mode && !halt_mode; endproperty
a_pcw: assert property (p_pcw) else $error("mode bits kept");
property p_rst;
	$rose(resetn) |-> !wb_ack_o && !stop_mode && !halt_mode && !cpu_on_sub;
endproperty
a_rst: assert property (p_rst) else $error("reset state");
property p_tick; cpu_clk_tick |=> !cpu_clk_tick [*3]; endproperty
a_tick: assert property (p_tick) else $error("tick gap");
property p_sub; cpu_on_sub |-> !stop_mode; endproperty
a_sub: assert property (p_sub) else $error("stop on sub");
endmodule // cscs_checker
bind cscs_top cscs_checker u_chk (.sys_clk, .resetn, .wb_adr_i, .wb_we_i, .wb_sel_i,
	.wb_cyc_i, .wb_stb_i, .wb_ack_o, .standby_release, .cpu_clk_tick, .stop_mode,
	.halt_mode, .main_osc_input_pin_gnd, .main_osc_enable, .cpu_on_sub);
`default_nettype wire

// File: dv/cpu_system_clock_select_test.sv
// Purpose: directed bench for cscs_top
// Assumes: sub pin toggles every 8 sys clocks
// Notes: every wait is bounded
`timescale 1ns/1ps
`default_nettype none
module cpu_system_clock_select_test;
logic sys_clk = 0, resetn = 0, wb_we_i = 0, wb_cyc_i = 0, wb_stb_i = 0;
logic memory_bank_enable_flag = 0, standby_release = 0, sub_clk_pin = 0;
logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'h0;
logic [31:0] wb_dat_i = 32'h0, r;
logic [2:0] sc = 3'h0;
wire [31:0] wb_dat_o;
wire [1:0] cpu_div_active;
wire wb_ack_o, cpu_clk_tick, stop_mode, halt_mode, main_osc_input_pin_gnd;
wire main_osc_enable, cpu_on_sub;
int fail_count = 0, samples_checked = 0, n;
cscs_top DUT (.sys_clk, .resetn, .wb_adr_i, .wb_dat_i, .wb_we_i, .wb_sel_i, .wb_cyc_i,
	.wb_stb_i, .wb_dat_o, .wb_ack_o, .memory_bank_enable_flag, .standby_release,
	.sub_clk_pin, .cpu_clk_tick, .stop_mode, .halt_mode, .main_osc_input_pin_gnd,
	.main_osc_enable, .cpu_on_sub, .cpu_div_active);
initial forever #2 sys_clk = ~sys_clk;
// Slow sub clock: pin period 16 sys clocks, so a sub machine cycle is 64
always @(posedge sys_clk) begin
	sc <= sc + 3'h1;
	if (sc == 3'h0) sub_clk_pin <= ~sub_clk_pin;
end
////////////////////////////////////////////////////////////
task summarize;
	$display("checks %0d mismatches %0d", samples_checked, fail_count);
	if (fail_count == 0 && samples_checked > 0) $display("verification passed");
	else $display("verification failed");
	$finish;
endtask
task chk(input string nm, input logic [31:0] s, e);
	samples_checked++;
	if (s !== e) begin
		fail_count++;
		$display("wrong value %s exp %h seen %h", nm, e, s);
	end
endtask
task wb(input logic [3:0] a, input logic w, input logic [31:0] d);
	int i;
	wb_adr_i <= a; wb_we_i <= w; wb_dat_i <= d; wb_sel_i <= 4'hF;
	wb_cyc_i <= 1; wb_stb_i <= 1;
	i = 0;
	do begin @(posedge sys_clk); i++; end while (wb_ack_o !== 1 && i < 50);
	if (i >= 50) begin fail_count++; summarize; end
	r = wb_dat_o;
	wb_cyc_i <= 0; wb_stb_i <= 0;
	@(posedge sys_clk);
endtask
// Cycles between two cpu ticks, bounded
task gap;
	int i;
	for (i = 0; i < 600 && cpu_clk_tick !== 1; i++) @(posedge sys_clk);
	@(posedge sys_clk);
	for (n = 1; n < 600 && cpu_clk_tick !== 1; n++) @(posedge sys_clk);
	if (i >= 600 || n >= 600) begin fail_count++; summarize; end
endtask
task wsub(input logic v);
	int i;
	for (i = 0; i < 3000 && cpu_on_sub !== v; i++) @(posedge sys_clk);
	if (cpu_on_sub !== v) begin fail_count++; summarize; end
endtask
////////////////////////////////////////////////////////////
task t_regs;
	wb(4'h0, 0, 0); chk("pcs", r, 0);
	wb(4'h4, 0, 0); chk("scs", r, 0);
	wb(4'h2, 1, 32'hF); wb(4'h2, 0, 0); chk("unmapped", r, 0);
	for (int k = 0; k < 4; k++) begin
		wb(4'h0, 1, 32'hC + k); wb(4'h0, 0, 0); chk("pcs", r, k);
	end
	$display("regs done");
endtask
task t_mode;
	memory_bank_enable_flag <= 1;
	wb(4'h8, 1, 2); wb(4'h0, 0, 0); chk("pcs", r, 32'h7);
	chk("halt", halt_mode, 1);
	standby_release <= 1; @(posedge sys_clk); standby_release <= 0;
	repeat (3) @(posedge sys_clk);
	chk("halt", halt_mode, 0);
	wb(4'h8, 1, 1); chk("stop", stop_mode, 1);
	chk("gnd", main_osc_input_pin_gnd, 1);
	chk("osc_en", main_osc_enable, 0);
	standby_release <= 1; @(posedge sys_clk); standby_release <= 0;
	repeat (3) @(posedge sys_clk);
	chk("stop", stop_mode, 0);
	memory_bank_enable_flag <= 0;
	$display("mode done");
endtask
task t_sub;
	// Divider left at 11 before going to sub, never 01
	wb(4'h4, 1, 9); wb(4'h4, 0, 0); chk("scs", r, 1);
	chk("sub", cpu_on_sub, 0);
	wsub(1); gap; chk("subgap", n, 64);
	// Stop command sent only with an on-board crystal assumed
	wb(4'h8, 1, 1); chk("stop", stop_mode, 0);
	// Oscillator stopped only on sub, long after the switch
	wb(4'h4, 1, 9); chk("gnd", main_osc_input_pin_gnd, 1);
	chk("stop", stop_mode, 0);
	wb(4'h4, 1, 1); wb(4'h4, 1, 0); wsub(0);
	gap; chk("maingap", n, 4);
	chk("div", cpu_div_active, 3);
	chk("osc_en", main_osc_enable, 1);
	wb(4'hC, 0, 0); chk("stat", r, 32'hC);
	$display("sub done");
endtask
initial begin
	repeat (12) @(posedge sys_clk);
	resetn <= 1;
	@(posedge sys_clk);
	t_regs; t_mode; t_sub;
	summarize;
end
endmodule // cpu_system_clock_select_test
`default_nettype wire
